// [src/lrc_consts.svh]
`ifndef LRC_CONSTS_SVH
`define LRC_CONSTS_SVH

// output count and the split point of the dual shift
`define LRC_OUTPUTS 160
`define LRC_HALF 80

// data clocks per line in 4-bit and 8-bit loading
`define LRC_CLKS_NARROW 6'h28
`define LRC_CLKS_WIDE 6'h14
`define LRC_LANES_NARROW 8'h04
`define LRC_LANES_WIDE 8'h08

// level-select codes for the analog output stage
`define LRC_LVL_GND 2'h0
`define LRC_LVL_LOWMID 2'h1
`define LRC_LVL_HIMID 2'h2
`define LRC_LVL_TOP 2'h3

// capture buffer
`define LRC_FIFO_DEPTH 32
`define LRC_FIFO_WIDTH 14

`endif

// [src/lrc_pkg.sv]
package lrc_pkg;
	typedef logic [1:0] lrc_level_t;
	typedef enum logic [1:0] {
		SEL_IDLE,
		SEL_ARMED,
		SEL_ACTIVE
	} lrc_sel_t;
endpackage : lrc_pkg

// [src/lrc_fifo.sv]
`timescale 1ns/1ps
module lrc_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr_reg[AW-1:0]];
	assign push = in_valid_i && !full;
	assign pop = out_ready_i && !empty;

	always_ff @(posedge core_clk_i)
	begin
		if (push)
		begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule : lrc_fifo

// [src/lrc_driver.sv]
`timescale 1ns/1ps
`include "lrc_consts.svh"
// Summary of operation
// - Segment mode, not blanked, frame invert high: low bit picks high-middle, high bit picks top.
// - Segment mode, not blanked, frame invert low: low bit picks low-middle, high bit ground.
// - Common mode levels follow frame invert and data, and blanking forces ground in both modes.
// - 4-bit loading fills a line in 40 data clocks, ordered by the direction pin.
// - 8-bit loading fills a line in 20 data clocks, ordered by the direction pin.
// - Segment data lanes are sampled on each falling edge of the data shift clock.
// - In segment mode the cascade output idles high and goes low for one data-clock period after a full line.
// - Common mode shifts one place on each falling edge of the line latch pulse.
// - Single shift with direction low runs 160 toward 1, fed from pin b, out on pin a.
// - Single shift with direction high runs 1 toward 160, fed from pin a, out on pin b.
// - Dual shift with direction high runs two 80-bit halves fed from pin a and the dual input.
// - Dual shift with direction low runs 160 toward 81 from the dual input, 80 toward 1 from b.
module lrc_driver (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// configuration pins
	input wire logic segment_mode_i,
	input wire logic width_or_split_select_i,
	input wire logic shift_dir_i,
	// timing controller inputs
	input wire logic data_shift_clock_i,
	input wire logic line_latch_pulse_i,
	input wire logic display_blank_n_i,
	input wire logic frame_invert_i,
	input wire logic [7:0] display_data_lanes_i,
	// cascade pins
	input wire logic cascade_io_a_i,
	output logic cascade_io_a_o,
	output logic cascade_io_a_oe_o,
	input wire logic cascade_io_b_i,
	output logic cascade_io_b_o,
	output logic cascade_io_b_oe_o,
	// level codes, two bits per output
	output logic [2*`LRC_OUTPUTS-1:0] drive_outputs_o
);
	logic xck_prev_reg;
	logic lp_prev_reg;
	logic xck_fall;
	logic lp_fall;
	lrc_pkg::lrc_sel_t sel_reg;
	logic [5:0] clk_cnt_reg;
	logic [5:0] clk_last;
	logic casc_low_reg;
	logic enable_in;
	logic [`LRC_OUTPUTS-1:0] data_latch_reg;
	logic [`LRC_OUTPUTS-1:0] line_latch_reg;
	logic [`LRC_OUTPUTS-1:0] shift_reg;
	logic [`LRC_OUTPUTS-1:0] level_data;
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;
	logic [`LRC_FIFO_WIDTH-1:0] pop_word;
	logic [7:0] lanes_w;
	logic [7:0] base;
	logic [7:0] k_idx;

	assign xck_fall = xck_prev_reg && !data_shift_clock_i;
	assign lp_fall = lp_prev_reg && !line_latch_pulse_i;
	assign clk_last = width_or_split_select_i ? `LRC_CLKS_WIDE - 6'h01 : `LRC_CLKS_NARROW - 6'h01;
	assign enable_in = shift_dir_i ? cascade_io_a_i : cascade_io_b_i;

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			xck_prev_reg <= 1'b0;
			lp_prev_reg <= 1'b0;
		end
		else
		begin
			xck_prev_reg <= data_shift_clock_i;
			lp_prev_reg <= line_latch_pulse_i;
		end
	end

	// chip select: armed by the latch pulse, active from the enable input going low until the last data clock
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sel_reg <= lrc_pkg::SEL_IDLE;
			clk_cnt_reg <= 6'h00;
			casc_low_reg <= 1'b0;
		end
		else
		begin
			if (casc_low_reg && xck_fall)
			begin
				casc_low_reg <= 1'b0;
			end
			case (sel_reg)
				lrc_pkg::SEL_IDLE:
				begin
					if (lp_fall && segment_mode_i)
					begin
						sel_reg <= lrc_pkg::SEL_ARMED;
					end
				end
				lrc_pkg::SEL_ARMED:
				begin
					clk_cnt_reg <= 6'h00;
					if (!enable_in)
					begin
						sel_reg <= lrc_pkg::SEL_ACTIVE;
					end
				end
				lrc_pkg::SEL_ACTIVE:
				begin
					// a full buffer holds the count, so a word is never half counted
					if (xck_fall && push_ready)
					begin
						if (clk_cnt_reg == clk_last)
						begin
							sel_reg <= lrc_pkg::SEL_IDLE;
							casc_low_reg <= 1'b1;
						end
						else
						begin
							clk_cnt_reg <= clk_cnt_reg + 6'h01;
						end
					end
				end
				default:
				begin
					sel_reg <= lrc_pkg::SEL_IDLE;
				end
			endcase
		end
	end

	assign push_valid = (sel_reg == lrc_pkg::SEL_ACTIVE) && xck_fall && segment_mode_i;
	// the line transfer stalls the drain so the latch copy sees a settled data latch
	assign pop_ready = !lp_fall;

	lrc_fifo #(
		.WIDTH(`LRC_FIFO_WIDTH),
		.DEPTH(`LRC_FIFO_DEPTH)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i({clk_cnt_reg, display_data_lanes_i}),
		.out_valid_o(pop_valid),
		.out_ready_i(pop_ready),
		.out_data_o(pop_word)
	);

	assign lanes_w = width_or_split_select_i ? `LRC_LANES_WIDE : `LRC_LANES_NARROW;
	assign k_idx = {2'h0, pop_word[13:8]};
	assign base = shift_dir_i ? 8'(lanes_w * k_idx) : 8'(8'hA0 - lanes_w * (k_idx + 8'h01));

	// data latch keeps loading while blanked; the line latch and the common shift register are cleared
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			data_latch_reg <= '0;
		end
		else if (pop_valid && pop_ready)
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (8'(i) < lanes_w)
				begin
					if (shift_dir_i)
					begin
						data_latch_reg[8'(base + lanes_w - 8'h01 - 8'(i))] <= pop_word[i];
					end
					else
					begin
						data_latch_reg[8'(base + 8'(i))] <= pop_word[i];
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			line_latch_reg <= '0;
		end
		else if (!display_blank_n_i)
		begin
			line_latch_reg <= '0;
		end
		else if (lp_fall && segment_mode_i)
		begin
			line_latch_reg <= data_latch_reg;
		end
	end

	// common mode shift register
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			shift_reg <= '0;
		end
		else if (!display_blank_n_i)
		begin
			shift_reg <= '0;
		end
		else if (lp_fall && !segment_mode_i)
		begin
			if (!width_or_split_select_i && !shift_dir_i)
			begin
				shift_reg <= {cascade_io_b_i, shift_reg[159:1]};
			end
			else if (!width_or_split_select_i)
			begin
				shift_reg <= {shift_reg[158:0], cascade_io_a_i};
			end
			else if (shift_dir_i)
			begin
				shift_reg <= {shift_reg[158:80], display_data_lanes_i[7],
					shift_reg[78:0], cascade_io_a_i};
			end
			else
			begin
				shift_reg <= {display_data_lanes_i[7], shift_reg[159:81],
					cascade_io_b_i, shift_reg[79:1]};
			end
		end
	end

	// cascade pins: the input end is released, the output end is driven
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cascade_io_a_o <= 1'b1;
			cascade_io_b_o <= 1'b1;
			cascade_io_a_oe_o <= 1'b0;
			cascade_io_b_oe_o <= 1'b0;
		end
		else
		begin
			cascade_io_a_oe_o <= !shift_dir_i;
			cascade_io_b_oe_o <= shift_dir_i;
			cascade_io_a_o <= segment_mode_i ? !casc_low_reg : shift_reg[0];
			cascade_io_b_o <= segment_mode_i ? !casc_low_reg : shift_reg[159];
		end
	end

	assign level_data = segment_mode_i ? line_latch_reg : shift_reg;

	generate
		for (genvar g = 0; g < `LRC_OUTPUTS; g++)
		begin : g_out
			always_ff @(posedge core_clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_GND;
				end
				else if (!display_blank_n_i)
				begin
					drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_GND;
				end
				else if (segment_mode_i)
				begin
					case ({frame_invert_i, level_data[g]})
						2'h0: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_LOWMID;
						2'h1: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_GND;
						2'h2: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_HIMID;
						default: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_TOP;
					endcase
				end
				else
				begin
					case ({frame_invert_i, level_data[g]})
						2'h0: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_LOWMID;
						2'h1: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_TOP;
						2'h2: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_HIMID;
						default: drive_outputs_o[2*g+1:2*g] <= `LRC_LVL_GND;
					endcase
				end
			end
		end
	endgenerate

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	blank_ground_a: assert property (!display_blank_n_i |=> drive_outputs_o == '0)
		else $error("blanking did not force ground");
	seg_inv_high_a: assert property (segment_mode_i && display_blank_n_i && frame_invert_i
		|=> drive_outputs_o[1:0]
		== ($past(line_latch_reg[0]) ? `LRC_LVL_TOP : `LRC_LVL_HIMID))
		else $error("segment high frame level wrong");
	seg_inv_low_a: assert property (segment_mode_i && display_blank_n_i && !frame_invert_i
		|=> drive_outputs_o[11:10]
		== ($past(line_latch_reg[5]) ? `LRC_LVL_GND : `LRC_LVL_LOWMID))
		else $error("segment low frame level wrong");
	com_level_a: assert property (!segment_mode_i && display_blank_n_i && !frame_invert_i
		|=> drive_outputs_o[319:318]
		== ($past(shift_reg[159]) ? `LRC_LVL_TOP : `LRC_LVL_LOWMID))
		else $error("common level wrong");
	line_end_pulse_a: assert property (sel_reg == lrc_pkg::SEL_ACTIVE && xck_fall && push_ready
		&& clk_cnt_reg == clk_last
		|=> casc_low_reg ##1 !(shift_dir_i ? cascade_io_b_o : cascade_io_a_o))
		else $error("cascade pulse missing after line");
	pulse_release_a: assert property (casc_low_reg && xck_fall && sel_reg == lrc_pkg::SEL_IDLE
		|=> !casc_low_reg)
		else $error("cascade pulse longer than one period");
	count_bound_a: assert property (clk_cnt_reg <= clk_last)
		else $error("data clock count out of range");
	single_left_a: assert property (!segment_mode_i && lp_fall && display_blank_n_i
		&& !width_or_split_select_i && !shift_dir_i |=> shift_reg[159] == $past(cascade_io_b_i))
		else $error("single left shift input wrong");
	single_right_a: assert property (!segment_mode_i && lp_fall && display_blank_n_i
		&& !width_or_split_select_i && shift_dir_i
		|=> shift_reg[0] == $past(cascade_io_a_i) && shift_reg[1] == $past(shift_reg[0]))
		else $error("single right shift wrong");
	dual_right_a: assert property (!segment_mode_i && lp_fall && display_blank_n_i
		&& width_or_split_select_i && shift_dir_i
		|=> shift_reg[80] == $past(display_data_lanes_i[7]))
		else $error("dual right upper input wrong");
	dual_left_a: assert property (!segment_mode_i && lp_fall && display_blank_n_i
		&& width_or_split_select_i && !shift_dir_i
		|=> shift_reg[159] == $past(display_data_lanes_i[7])
		&& shift_reg[79] == $past(cascade_io_b_i))
		else $error("dual left inputs wrong");
	hold_no_lp_a: assert property (!segment_mode_i && display_blank_n_i && !lp_fall
		|=> $stable(shift_reg))
		else $error("shift without latch pulse edge");
endmodule : lrc_driver

// [tb/lrc_ctrl_model.sv]
`timescale 1ns/1ps
module lrc_ctrl_model (
	// clock
	input wire logic core_clk_i,
	// timing controller outputs
	output logic data_shift_clock_o,
	output logic line_latch_pulse_o,
	output logic display_blank_n_o,
	output logic frame_invert_o,
	output logic cascade_drive_o,
	output logic [7:0] display_data_lanes_o
);
	initial
	begin
		data_shift_clock_o = 1'b0;
		line_latch_pulse_o = 1'b0;
		display_blank_n_o = 1'b0;
		frame_invert_o = 1'b0;
		cascade_drive_o = 1'b1;
		display_data_lanes_o = 8'h00;
	end

	task step(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : step

	task latch();
		line_latch_pulse_o <= 1'b1;
		step(2);
		line_latch_pulse_o <= 1'b0;
		step(2);
	endtask : latch

	// lanes carry the inverse between words so stale data never looks valid
	task word(input logic [7:0] d);
		data_shift_clock_o <= 1'b1;
		display_data_lanes_o <= ~display_data_lanes_o;
		step(2);
		display_data_lanes_o <= d;
		data_shift_clock_o <= 1'b0;
		step(2);
	endtask : word

	task set_blank(input logic v);
		display_blank_n_o <= v;
	endtask : set_blank

	task set_invert(input logic v);
		frame_invert_o <= v;
	endtask : set_invert

	task set_cascade(input logic v);
		cascade_drive_o <= v;
	endtask : set_cascade

	task shift(input logic v, input logic l7);
		cascade_drive_o <= v;
		display_data_lanes_o[7] <= l7;
		latch();
	endtask : shift
endmodule : lrc_ctrl_model

// [tb/lcd_row_column_driver_logic_tb.sv]
`timescale 1ns/1ps
module lcd_row_column_driver_logic_tb;
	logic core_clk_i = 1'b0;
	logic rstn_i;
	logic seg;
	logic wide;
	logic dir;
	logic a_o, a_oe, b_o, b_oe, data_shift_clock, lp, blank_n, fr, pin;
	logic a_in;
	logic b_in;
	logic [7:0] lanes;
	logic [319:0] drv;
	logic [159:0] bits;
	int n_errors = 0;
	int check_count = 0;

	initial forever #5 core_clk_i = ~core_clk_i;

	lrc_ctrl_model ctl (.core_clk_i(core_clk_i), .data_shift_clock_o(data_shift_clock),
		.line_latch_pulse_o(lp), .display_blank_n_o(blank_n), .frame_invert_o(fr),
		.cascade_drive_o(pin), .display_data_lanes_o(lanes));

	// a driven pin reads back its own value, a released one sees the controller
	assign a_in = a_oe ? a_o : pin;
	assign b_in = b_oe ? b_o : pin;

	lrc_driver dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .segment_mode_i(seg),
		.width_or_split_select_i(wide), .shift_dir_i(dir), .data_shift_clock_i(data_shift_clock),
		.line_latch_pulse_i(lp), .display_blank_n_i(blank_n), .frame_invert_i(fr),
		.display_data_lanes_i(lanes), .cascade_io_a_i(a_in),
		.cascade_io_a_o(a_o), .cascade_io_a_oe_o(a_oe), .cascade_io_b_i(b_in),
		.cascade_io_b_o(b_o), .cascade_io_b_oe_o(b_oe), .drive_outputs_o(drv));

	task close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	task chk(input logic [319:0] seen, input logic [319:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [319:0] lv(input logic [159:0] b, input logic s, input logic f);
		logic [319:0] r;
		for (int j = 0; j < 160; j++)
			r[2*j+:2] = s ? (f ? {1'b1, b[j]} : {1'b0, ~b[j]}) : (f ? {~b[j], 1'b0} : {b[j], 1'b1});
		return r;
	endfunction : lv

	// mode pins are static, so every change goes through a reset
	task cfg(input logic s, input logic w, input logic d);
		rstn_i <= 1'b0;
		seg <= s;
		wide <= w;
		dir <= d;
		ctl.step(5);
		rstn_i <= 1'b1;
		ctl.step(2);
	endtask : cfg

	task seg_line(input logic w, input logic d);
		int nw;
		int lw;
		int idx;
		logic [7:0] v;
		nw = w ? 20 : 40;
		lw = w ? 8 : 4;
		bits = '0;
		ctl.latch();
		ctl.set_cascade(1'b0);
		ctl.step(2);
		for (int k = 0; k < nw; k++)
		begin
			v = 8'(k * 29 + 83);
			for (int i = 0; i < lw; i++)
			begin
				idx = d ? lw * k + lw - 1 - i : 160 - lw * (k + 1) + i;
				bits[idx] = v[i];
			end
			ctl.word(v);
		end
		ctl.set_cascade(1'b1);
		ctl.step(1);
		chk(320'({d ? b_oe : a_oe, d ? b_o : a_o}), 320'h2);
		ctl.word(8'h00);
		ctl.step(1);
		chk(320'({d ? b_oe : a_oe, d ? b_o : a_o}), 320'h3);
		ctl.step(4);
		ctl.latch();
		ctl.step(3);
	endtask : seg_line

	initial
	begin
		#500000;
		n_errors++;
		close_out();
	end

	initial
	begin
		int f;
		int nsh;
		rstn_i <= 1'b0;
		seg <= 1'b1;
		wide <= 1'b0;
		dir <= 1'b0;
		ctl.step(1);
		cfg(1'b1, 1'b1, 1'b0);
		chk(320'({a_oe, a_o}), 320'h3);
		ctl.step(3);
		ctl.set_blank(1'b1);
		for (int c = 0; c < 4; c++)
		begin
			cfg(1'b1, c[1], c[0]);
			ctl.set_invert(c[0] ^ c[1]);
			seg_line(c[1], c[0]);
			chk(drv, lv(bits, 1'b1, c[0] ^ c[1]));
		end
		ctl.set_invert(1'b1);
		ctl.step(2);
		chk(drv, lv(bits, 1'b1, 1'b1));
		ctl.set_blank(1'b0);
		ctl.step(2);
		chk(drv, 320'h0);
		ctl.set_blank(1'b1);
		ctl.step(2);
		chk(drv, lv(160'h0, 1'b1, 1'b1));
		for (int c = 0; c < 4; c++)
		begin
			cfg(1'b0, c[1], c[0]);
			ctl.set_invert(1'b1);
			ctl.shift(1'b1, 1'b1);
			ctl.shift(1'b0, ~c[1]);
			bits = '0;
			f = c[0] ? 1 : 158;
			bits[f] = 1'b1;
			if (c[1])
				bits[c[0] ? 81 : 78] = 1'b1;
			ctl.step(2);
			chk(drv, lv(bits, 1'b0, 1'b1));
			chk(320'({a_oe, b_oe}), c[0] ? 320'h1 : 320'h2);
			ctl.set_invert(1'b0);
			ctl.step(2);
			chk(drv, lv(bits, 1'b0, 1'b0));
			// the first marked bit reaches the output end after 160 latch pulses in single shift, 80 in dual shift
			nsh = c[1] ? 80 : 160;
			for (int n = 2; n < nsh - 1; n++)
			begin
				ctl.shift(1'b0, 1'b0);
			end
			ctl.step(2);
			chk(320'(c[0] ? b_o : a_o), 320'h0);
			ctl.shift(1'b0, 1'b0);
			ctl.step(2);
			chk(320'(c[0] ? b_o : a_o), 320'h1);
		end
		ctl.set_blank(1'b0);
		ctl.step(2);
		chk(drv, 320'h0);
		ctl.set_blank(1'b1);
		ctl.step(2);
		chk(drv, lv(160'h0, 1'b0, 1'b0));
		ctl.set_blank(1'b0);
		ctl.step(2);
		close_out();
	end
endmodule : lcd_row_column_driver_logic_tb
